// ===== fsq_pkg.sv
// Summary of operation
// - Boot-source bit 0 at reset: start executing from the factory boot ROM.
// - Boot-source bit 1 at reset: start fetching at flash location zero.
// - While in boot ROM, the serial port is watched for programming commands.
// - Boot ROM holds 1K bytes of programming and emulation support code.
// - High address byte is bits 15..8, low byte bits 7..0.
// - Both address bytes clear to zero on reset.
// - A read operation leaves the fetched byte in the read-data register.
// - Read-data register is readable from flash or boot ROM code.
// - Read-data register has no defined reset value.
// - Internal programming control register is not reachable by user software.
// - Pulse-timing register resets to the 10 MHz value; set before write or erase.
// - Matching 6-bit key sets flag 8 instruction cycles; jump-to-boot needs it.
package fsq_pkg;

  localparam int          PADDR_W        = 8;
  localparam logic [7:0]  OFS_ADDR_HI    = 8'h00;
  localparam logic [7:0]  OFS_ADDR_LO    = 8'h04;
  localparam logic [7:0]  OFS_READ_DATA  = 8'h08;
  localparam logic [7:0]  OFS_WRITE_DATA = 8'h0C;
  localparam logic [7:0]  OFS_PULSE_TIM  = 8'h10;
  localparam logic [7:0]  OFS_KEY        = 8'h14;
  localparam logic [7:0]  OFS_STATUS     = 8'h18;

  localparam logic [7:0]  ADDR_RST       = 8'h00;
  localparam logic [7:0]  PULSE_TIM_RST  = 8'h7B;
  localparam logic [7:0]  PULSE_TIM_MASK = 8'h7F;

  localparam int          KEY_LSB        = 2;
  localparam logic [5:0]  KEY_VALUE      = 6'h26;
  localparam int          KEY_CYCLES     = 8;

  localparam int          STAT_BUSY      = 0;
  localparam int          STAT_KEY       = 1;
  localparam int          STAT_IN_BOOT   = 2;
  localparam int          STAT_BOOT_SEL  = 3;
  localparam int          STAT_DONE      = 4;

  localparam logic [15:0] FLASH_START    = 16'h0000;
  localparam logic [15:0] BOOT_START     = 16'h0000;
  localparam int          BOOT_ROM_BYTES = 1024;
  localparam logic [15:0] OPTION_ALIAS   = 16'hFFFF;
  localparam logic [15:0] OPTION_PHYS    = 16'h7FFF;

  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          INSTR_CYCLE_NS = 500;
  localparam int          INSTR_DIV      = INSTR_CYCLE_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FSQ_OP_READ       = 2'b00,
    FSQ_OP_WRITE      = 2'b01,
    FSQ_OP_PAGE_ERASE = 2'b10,
    FSQ_OP_MASS_ERASE = 2'b11
  } fsq_op_t;

  typedef enum logic [1:0] {
    FSQ_IDLE = 2'b00,
    FSQ_RUN  = 2'b01,
    FSQ_DONE = 2'b10
  } fsq_state_t;

endpackage

// ===== fsq_key_timer.sv
`timescale 1ns/1ns
module fsq_key_timer #(
  parameter int DIV    = fsq_pkg::INSTR_DIV,
  parameter int CYCLES = fsq_pkg::KEY_CYCLES
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Control
  input  wire logic key_ok_i,
  input  wire logic key_bad_i,
  input  wire logic freeze_i,
  // Status
  output logic      key_set_o
);

  localparam int DW = $clog2(DIV + 1);
  localparam int CW = $clog2(CYCLES + 1);

  logic [DW-1:0] div_q;
  logic          tick;
  logic [CW-1:0] left_q;

  assign tick = (div_q == DW'(DIV - 1));

  // Instruction-cycle enable pulse
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      div_q <= '0;
    else if (tick)
      div_q <= '0;
    else
      div_q <= div_q + DW'(1);
  end

  // Key window counts instruction cycles; a breakpoint freezes it
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      left_q <= '0;
    else if (key_ok_i)
      left_q <= CW'(CYCLES);
    else if (key_bad_i)
      left_q <= '0;
    else if (tick && !freeze_i && left_q != '0)
      left_q <= left_q - CW'(1);
  end

  assign key_set_o = (left_q != '0);

endmodule // fsq_key_timer

// ===== fsq_boot_sel.sv
`timescale 1ns/1ns
module fsq_boot_sel (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Option bit and flow control
  input  wire logic        boot_source_select_bit_i,
  input  wire logic        jump_boot_i,
  input  wire logic        return_flash_i,
  // Status
  output logic             in_boot_o,
  output logic             boot_sel_o,
  output logic             start_valid_o,
  output logic [15:0]      start_addr_o
);

  logic init_q;

  // Option bit is caught on the first edge after reset release
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      init_q <= 1'b1;
    else
      init_q <= 1'b0;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      boot_sel_o <= 1'b0;
    else if (init_q)
      boot_sel_o <= boot_source_select_bit_i;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      in_boot_o <= 1'b1;
    else if (init_q)
      in_boot_o <= !boot_source_select_bit_i;
    else if (jump_boot_i)
      in_boot_o <= 1'b1;
    else if (return_flash_i)
      in_boot_o <= 1'b0;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      start_valid_o <= 1'b0;
      start_addr_o  <= 16'h0000;
    end
    else
    begin
      start_valid_o <= init_q;
      if (init_q)
        start_addr_o <= boot_source_select_bit_i ? fsq_pkg::FLASH_START
                                                 : fsq_pkg::BOOT_START;
    end
  end

endmodule // fsq_boot_sel

// ===== fsq_regs.sv
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
module fsq_regs #(
  parameter int BOOT_ROM_BYTES = fsq_pkg::BOOT_ROM_BYTES,
  parameter int KEY_CYCLES     = fsq_pkg::KEY_CYCLES,
  parameter int INSTR_DIV      = fsq_pkg::INSTR_DIV
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  // APB slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [fsq_pkg::PADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic [31:0]                     prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // Factory control path
  input  wire logic                       ctl_cmd_valid_i,
  input  wire logic [1:0]                 ctl_cmd_op_i,
  output logic                            ctl_cmd_ready_o,
  // Core flow
  input  wire logic                       jump_to_boot_instruction_i,
  input  wire logic                       return_to_flash_i,
  input  wire logic                       breakpoint_i,
  output logic                            jump_taken_boot_o,
  output logic                            jump_taken_flash_o,
  output logic                            exec_from_boot_o,
  output logic                            serial_monitor_en_o,
  output logic                            fetch_start_valid_o,
  output logic [15:0]                     fetch_start_addr_o,
  output logic [$clog2(BOOT_ROM_BYTES)-1:0] boot_rom_limit_o,
  // Option bit
  input  wire logic                       boot_source_select_bit_i,
  // Flash array
  output logic                            flash_req_o,
  output logic [1:0]                      flash_op_o,
  output logic [15:0]                     flash_addr_o,
  output logic [7:0]                      flash_wdata_o,
  output logic [7:0]                      flash_pulse_o,
  input  wire logic                       flash_done_i,
  input  wire logic [7:0]                 flash_rdata_i
);

  logic [7:0]          prog_address_high_byte_q;
  logic [7:0]          prog_address_low_byte_q;
  logic [7:0]          prog_read_data_q;
  logic [7:0]          prog_write_data_q;
  logic [7:0]          program_pulse_timing_q;
  logic                done_q;
  logic [15:0]         op_addr_q;
  logic [1:0]          op_q;
  fsq_pkg::fsq_state_t state_q;
  fsq_pkg::fsq_state_t state_d;

  logic                setup;
  logic                access;
  logic                wr_acc;
  logic                busy;
  logic                mapped;
  logic                locked;
  logic                key_set;
  logic                key_wr;
  logic                key_ok;
  logic                in_boot;
  logic                boot_sel;
  logic                cmd_take;
  logic [15:0]         cur_addr;
  logic [31:0]         rd_mux;

  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h000000, v};
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign setup   = psel_i && !penable_i;
  assign access  = psel_i && penable_i;
  assign busy    = (state_q != fsq_pkg::FSQ_IDLE);
  assign cur_addr = {prog_address_high_byte_q, prog_address_low_byte_q};

  // Only the listed offsets answer; the control register has none
  always_comb
  begin
    mapped = hit(paddr_i, fsq_pkg::OFS_ADDR_HI)    ||
             hit(paddr_i, fsq_pkg::OFS_ADDR_LO)    ||
             hit(paddr_i, fsq_pkg::OFS_READ_DATA)  ||
             hit(paddr_i, fsq_pkg::OFS_WRITE_DATA) ||
             hit(paddr_i, fsq_pkg::OFS_PULSE_TIM)  ||
             hit(paddr_i, fsq_pkg::OFS_KEY)        ||
             hit(paddr_i, fsq_pkg::OFS_STATUS);
  end

  // Operands may not change under a running operation
  always_comb
  begin
    locked = busy && pwrite_i &&
             (hit(paddr_i, fsq_pkg::OFS_ADDR_HI)    ||
              hit(paddr_i, fsq_pkg::OFS_ADDR_LO)    ||
              hit(paddr_i, fsq_pkg::OFS_WRITE_DATA) ||
              hit(paddr_i, fsq_pkg::OFS_PULSE_TIM));
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = access && (!mapped || locked);
  assign wr_acc    = access && pwrite_i && mapped && !locked;

  // Read mux; read data is open to either execution source
  always_comb
  begin
    rd_mux = 32'h00000000;
    case (paddr_i)
      fsq_pkg::OFS_ADDR_HI:    rd_mux = zext8(prog_address_high_byte_q);
      fsq_pkg::OFS_ADDR_LO:    rd_mux = zext8(prog_address_low_byte_q);
      fsq_pkg::OFS_READ_DATA:  rd_mux = zext8(prog_read_data_q);
      fsq_pkg::OFS_WRITE_DATA: rd_mux = zext8(prog_write_data_q);
      fsq_pkg::OFS_PULSE_TIM:  rd_mux = zext8(program_pulse_timing_q);
      fsq_pkg::OFS_STATUS:
      begin
        rd_mux[fsq_pkg::STAT_BUSY]     = busy;
        rd_mux[fsq_pkg::STAT_KEY]      = key_set;
        rd_mux[fsq_pkg::STAT_IN_BOOT]  = in_boot;
        rd_mux[fsq_pkg::STAT_BOOT_SEL] = boot_sel;
        rd_mux[fsq_pkg::STAT_DONE]     = done_q;
      end
      default:                 rd_mux = 32'h00000000;
    endcase
  end

  // Read data is captured in the setup cycle, valid in the access cycle
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      prdata_o <= 32'h00000000;
    else if (setup && !pwrite_i)
      prdata_o <= rd_mux;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      prog_address_high_byte_q <= fsq_pkg::ADDR_RST;
    else if (wr_acc && hit(paddr_i, fsq_pkg::OFS_ADDR_HI))
      prog_address_high_byte_q <= pwdata_i[7:0];
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      prog_address_low_byte_q <= fsq_pkg::ADDR_RST;
    else if (wr_acc && hit(paddr_i, fsq_pkg::OFS_ADDR_LO))
      prog_address_low_byte_q <= pwdata_i[7:0];
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      prog_write_data_q <= 8'h00;
    else if (wr_acc && hit(paddr_i, fsq_pkg::OFS_WRITE_DATA))
      prog_write_data_q <= pwdata_i[7:0];
  end

  // Top bit is read-only zero
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      program_pulse_timing_q <= fsq_pkg::PULSE_TIM_RST;
    else if (wr_acc && hit(paddr_i, fsq_pkg::OFS_PULSE_TIM))
      program_pulse_timing_q <= pwdata_i[7:0] & fsq_pkg::PULSE_TIM_MASK;
  end

  // No reset on purpose: content is undefined until the first read
  always_ff @(posedge clk_i)
  begin
    if (state_q == fsq_pkg::FSQ_RUN && flash_done_i && op_q == fsq_pkg::FSQ_OP_READ)
      prog_read_data_q <= flash_rdata_i;
  end

  // Key register
  assign key_wr = wr_acc && hit(paddr_i, fsq_pkg::OFS_KEY);
  assign key_ok = key_wr && (pwdata_i[7:fsq_pkg::KEY_LSB] == fsq_pkg::KEY_VALUE);

  fsq_key_timer #(
    .DIV    (INSTR_DIV),
    .CYCLES (KEY_CYCLES)
  ) u_key (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .key_ok_i  (key_ok),
    .key_bad_i (key_wr && !key_ok),
    .freeze_i  (breakpoint_i),
    .key_set_o (key_set)
  );

  // Jump-to-boot goes to boot ROM only while the key is set
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      jump_taken_boot_o  <= 1'b0;
      jump_taken_flash_o <= 1'b0;
    end
    else
    begin
      jump_taken_boot_o  <= jump_to_boot_instruction_i && key_set;
      jump_taken_flash_o <= jump_to_boot_instruction_i && !key_set;
    end
  end

  fsq_boot_sel u_boot (
    .clk_i                    (clk_i),
    .reset_i                  (reset_i),
    .boot_source_select_bit_i (boot_source_select_bit_i),
    .jump_boot_i              (jump_to_boot_instruction_i && key_set),
    .return_flash_i           (return_to_flash_i),
    .in_boot_o                (in_boot),
    .boot_sel_o               (boot_sel),
    .start_valid_o            (fetch_start_valid_o),
    .start_addr_o             (fetch_start_addr_o)
  );

  assign exec_from_boot_o    = in_boot;
  assign serial_monitor_en_o = in_boot;
  assign boot_rom_limit_o    = ($clog2(BOOT_ROM_BYTES))'(BOOT_ROM_BYTES - 1);

  // Operations start only from the factory path, never from the bus
  assign ctl_cmd_ready_o = !busy && in_boot;
  assign cmd_take        = ctl_cmd_valid_i && ctl_cmd_ready_o;

  // Operation sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      fsq_pkg::FSQ_IDLE: if (cmd_take) state_d = fsq_pkg::FSQ_RUN;
      fsq_pkg::FSQ_RUN:  if (flash_done_i) state_d = fsq_pkg::FSQ_DONE;
      fsq_pkg::FSQ_DONE: state_d = fsq_pkg::FSQ_IDLE;
      default:           state_d = fsq_pkg::FSQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      state_q <= fsq_pkg::FSQ_IDLE;
    else
      state_q <= state_d;
  end

  // Address and operation sampled once, at the start
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      op_addr_q <= 16'h0000;
      op_q      <= 2'b00;
    end
    else if (cmd_take)
    begin
      op_addr_q <= (cur_addr == fsq_pkg::OPTION_ALIAS) ? fsq_pkg::OPTION_PHYS : cur_addr;
      op_q      <= ctl_cmd_op_i;
    end
  end

  // Completion flag: set by hardware, cleared by writing status; set wins
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      done_q <= 1'b0;
    else if (state_q == fsq_pkg::FSQ_DONE)
      done_q <= 1'b1;
    else if (wr_acc && hit(paddr_i, fsq_pkg::OFS_STATUS) && pwdata_i[fsq_pkg::STAT_DONE])
      done_q <= 1'b0;
  end

  assign flash_req_o   = (state_q == fsq_pkg::FSQ_RUN);
  assign flash_op_o    = op_q;
  assign flash_addr_o  = op_addr_q;
  assign flash_wdata_o = prog_write_data_q;
  assign flash_pulse_o = program_pulse_timing_q;

endmodule // fsq_regs

// ===== fsq_props.sv
`timescale 1ns/1ns
module fsq_props (
  // Clock and reset
  input wire logic                        clk_i,
  input wire logic                        reset_i,
  // Register bus
  input wire logic                        psel_i,
  input wire logic                        penable_i,
  input wire logic [fsq_pkg::PADDR_W-1:0] paddr_i,
  input wire logic                        pslverr_o,
  // Control and flow
  input wire logic                        ctl_cmd_valid_i,
  input wire logic                        ctl_cmd_ready_o,
  input wire logic                        jump_to_boot_instruction_i,
  input wire logic                        jump_taken_boot_o,
  input wire logic                        jump_taken_flash_o,
  input wire logic                        exec_from_boot_o,
  input wire logic                        serial_monitor_en_o,
  // Flash array
  input wire logic                        flash_req_o,
  input wire logic [15:0]                 flash_addr_o,
  input wire logic                        flash_done_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_unmapped_err: assert property (
    psel_i && penable_i && paddr_i > 8'h18 |-> pslverr_o) else $error("unmapped access accepted");
  chk_cmd_gate: assert property (
    ctl_cmd_ready_o |-> exec_from_boot_o && !flash_req_o) else $error("command path open outside boot");
  chk_req_start: assert property (
    ctl_cmd_valid_i && ctl_cmd_ready_o |=> flash_req_o) else $error("operation did not start");
  chk_req_end: assert property (
    flash_req_o && flash_done_i |=> !flash_req_o [*2]) else $error("request not ended by done");
  chk_addr_hold: assert property (
    flash_req_o |=> !flash_req_o || $stable(flash_addr_o)) else $error("address moved during operation");
  chk_option_remap: assert property (
    $rose(flash_req_o) |-> flash_addr_o != 16'hFFFF) else $error("option alias not remapped");
  chk_jump_outcome: assert property (
    jump_to_boot_instruction_i |=> jump_taken_boot_o ^ jump_taken_flash_o) else $error("jump outcome wrong");
  chk_boot_entry: assert property (
    jump_taken_boot_o |=> exec_from_boot_o) else $error("boot entry missing");
  chk_monitor_boot: assert property (
    serial_monitor_en_o == exec_from_boot_o) else $error("serial monitor not tied to boot");
endmodule // fsq_props

// ===== fsq_flash_model.sv
`timescale 1ns/1ns
module fsq_flash_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Sequencer side
  input  wire logic        req_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        slow_i,
  output logic             done_o,
  output logic [7:0]       rdata_o
);
  logic [3:0] wait_q;
  logic       hit;

  assign hit = req_i && !done_o && wait_q == (slow_i ? 4'h9 : 4'h1);

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wait_q <= 4'h0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= hit;
      if (hit)
        wait_q <= 4'h0;
      else if (req_i && !done_o)
        wait_q <= wait_q + 4'h1;
    end
  end

  // Byte valid only with done; toggles otherwise so stale data never matches
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_o <= 8'hA5;
    else if (hit)
      rdata_o <= addr_i[15:8] ^ addr_i[7:0] ^ 8'h3C;
    else
      rdata_o <= ~rdata_o;
  end
endmodule // fsq_flash_model

// ===== testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic cv, rdy, jb, rf, jtb, jtf, exb, mon, fsv, bsel, req, done, slow, rerr;
  logic [7:0] paddr_i, fwd, fpl, frd;
  logic [31:0] pwdata_i, prdata_o, rdat;
  logic [1:0] cop, fop;
  logic [15:0] fsa, fa;
  logic [9:0] lim;
  int errors;
  int checked;

  fsq_regs #(.INSTR_DIV(2)) uut (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .ctl_cmd_valid_i(cv), .ctl_cmd_op_i(cop),
    .ctl_cmd_ready_o(rdy), .jump_to_boot_instruction_i(jb), .return_to_flash_i(rf),
    .breakpoint_i(1'b0), .jump_taken_boot_o(jtb), .jump_taken_flash_o(jtf),
    .exec_from_boot_o(exb), .serial_monitor_en_o(mon), .fetch_start_valid_o(fsv),
    .fetch_start_addr_o(fsa), .boot_rom_limit_o(lim), .boot_source_select_bit_i(bsel),
    .flash_req_o(req), .flash_op_o(fop), .flash_addr_o(fa), .flash_wdata_o(fwd),
    .flash_pulse_o(fpl), .flash_done_i(done), .flash_rdata_i(frd));

  fsq_flash_model array (.clk_i(clk_i), .reset_i(reset_i), .req_i(req), .addr_i(fa),
    .slow_i(slow), .done_o(done), .rdata_o(frd));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("Counts: %0d checks, %0d mismatches", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic lim_chk(input int n);
    if (n >= 50)
    begin
      errors++;
      $display("ERROR %0t wait timed out", $time);
      finish_test();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 50);
    lim_chk(n);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // Idle cycle, so the next call never drives psel twice in one step
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    cmp(rdat, e, m);
  endtask

  task automatic op(input logic [1:0] o, input logic [15:0] ea, input string m);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    lim_chk(n);
    cv <= 1'b1;
    cop <= o;
    @(posedge clk_i);
    cv <= 1'b0;
    @(posedge clk_i);
    cmp(req, 1'b1, m);
    cmp(fop, o, m);
    cmp(fa, ea, m);
    if (slow)
    begin
      wr(fsq_pkg::OFS_ADDR_HI, 32'hEE);
      cmp(rerr, 1'b1, "busy write");
    end
    n = 0;
    while (req !== 1'b0 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    lim_chk(n);
    repeat (2) @(posedge clk_i);
  endtask

  task automatic jump(input logic boot, input string m);
    jb <= 1'b1;
    @(posedge clk_i);
    jb <= 1'b0;
    @(posedge clk_i);
    cmp(jtb, boot, m);
    cmp(jtf, !boot, m);
  endtask

  initial
  begin
    logic [15:0] a;
    errors = 0;
    checked = 0;
    {reset_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {1'b1, 43'h0};
    {cv, cop, jb, rf, bsel, slow} = 7'h0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(fsq_pkg::OFS_ADDR_HI, 32'h0, "hi reset");
    rd(fsq_pkg::OFS_ADDR_LO, 32'h0, "lo reset");
    rd(fsq_pkg::OFS_PULSE_TIM, 32'h7B, "pulse reset");
    cmp(exb, 1'b1, "boot after reset");
    cmp(mon, 1'b1, "serial monitor");
    cmp(fsa, 16'h0000, "fetch start");
    cmp(lim, 10'd1023, "boot size");
    $display("Test reset done");
    slow <= 1'b1;
    wr(fsq_pkg::OFS_ADDR_HI, 32'h12);
    wr(fsq_pkg::OFS_ADDR_LO, 32'h34);
    op(fsq_pkg::FSQ_OP_READ, 16'h1234, "read op");
    rd(fsq_pkg::OFS_ADDR_HI, 32'h12, "hi held");
    rd(fsq_pkg::OFS_STATUS, 32'h14, "status done");
    wr(fsq_pkg::OFS_STATUS, 32'h10);
    rd(fsq_pkg::OFS_STATUS, 32'h04, "done cleared");
    rd(fsq_pkg::OFS_READ_DATA, 32'h1234 >> 8 ^ 32'h34 ^ 32'h3C, "read data");
    slow <= 1'b0;
    wr(fsq_pkg::OFS_ADDR_HI, 32'hFF);
    wr(fsq_pkg::OFS_ADDR_LO, 32'hFF);
    op(fsq_pkg::FSQ_OP_READ, 16'h7FFF, "option read");
    rd(fsq_pkg::OFS_READ_DATA, 32'h7F ^ 32'hFF ^ 32'h3C, "option data");
    $display("Test read done");
    wr(fsq_pkg::OFS_WRITE_DATA, 32'h5A);
    wr(fsq_pkg::OFS_PULSE_TIM, 32'hFF);
    rd(fsq_pkg::OFS_PULSE_TIM, 32'h7F, "pulse bit7");
    for (int i = 1; i < 4; i++)
    begin
      a = (i == 3) ? 16'h0000 : 16'h0200;
      wr(fsq_pkg::OFS_ADDR_HI, {24'h0, a[15:8]});
      wr(fsq_pkg::OFS_ADDR_LO, {24'h0, a[7:0]});
      op(i[1:0], a, "write or erase");
      cmp(fwd, 8'h5A, "write data");
      cmp(fpl, 8'h7F, "pulse timing");
    end
    apb(1'b0, 8'h1C, 32'h0);
    cmp(rerr, 1'b1, "unmapped");
    $display("Test program done");
    wr(fsq_pkg::OFS_KEY, 32'h9B);
    jump(1'b1, "keyed jump");
    wr(fsq_pkg::OFS_KEY, 32'h94);
    jump(1'b0, "bad key");
    wr(fsq_pkg::OFS_KEY, 32'h98);
    repeat (20) @(posedge clk_i);
    jump(1'b0, "key expired");
    rf <= 1'b1;
    @(posedge clk_i);
    rf <= 1'b0;
    repeat (2) @(posedge clk_i);
    cmp(rdy, 1'b0, "no cmd in flash");
    $display("Test key done");
    bsel <= 1'b1;
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    cmp(fsv, 1'b1, "start pulse");
    @(posedge clk_i);
    cmp(fsv, 1'b0, "start pulse end");
    cmp(exb, 1'b0, "flash start");
    cmp(mon, 1'b0, "monitor off");
    cmp(fsa, 16'h0000, "flash origin");
    $display("Test boot select done");
    finish_test();
  end
endmodule // testbench

bind fsq_regs fsq_props chk (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .pslverr_o(pslverr_o), .ctl_cmd_valid_i(ctl_cmd_valid_i),
  .ctl_cmd_ready_o(ctl_cmd_ready_o), .jump_to_boot_instruction_i(jump_to_boot_instruction_i),
  .jump_taken_boot_o(jump_taken_boot_o), .jump_taken_flash_o(jump_taken_flash_o),
  .exec_from_boot_o(exec_from_boot_o), .serial_monitor_en_o(serial_monitor_en_o),
  .flash_req_o(flash_req_o), .flash_addr_o(flash_addr_o), .flash_done_i(flash_done_i));
